// [core/src_ctl_defs.svh]
// Register offsets, field positions, reset values and counts for the converter control.
`ifndef SRC_CTL_DEFS_SVH
`define SRC_CTL_DEFS_SVH

`define ADDR_CONTROL_ONE 7'h2D
`define ADDR_CONTROL_TWO 7'h2E
`define ADDR_ATTEN_LEFT 7'h30
`define ADDR_ATTEN_RIGHT 7'h31
`define ADDR_PAGE 7'h7F

`define RESET_CONTROL_ONE 8'h00
`define RESET_CONTROL_TWO 8'h00
`define RESET_ATTEN 8'h00
`define RESET_PAGE 2'h0
`define PAGE_CONTROL 2'h0

`define WMASK_CONTROL_ONE 8'h5F
`define WMASK_CONTROL_TWO 8'h3F

`define ONE_INSEL_LSB 0
`define ONE_CLKSEL_LSB 2
`define ONE_MUTE_BIT 4
`define ONE_TRACK_BIT 6
`define TWO_GRP_LSB 0
`define TWO_DDN_BIT 2
`define TWO_DEM_LSB 3
`define TWO_AUTO_BIT 5

`define PREBUF_64 7'h40
`define PREBUF_32 7'h20
`define PREBUF_16 7'h10
`define PREBUF_8 7'h08

`define ATTEN_STEPS_PER_SHIFT 8'h0C
`define GAIN_FRAC_BITS 8'h10

`endif

// [core/src_ctl_pkg.sv]
// Types shared by the converter control files.
package src_ctl_pkg;

	typedef struct packed {
		logic valid;
		logic signed [23:0] left;
		logic signed [23:0] right;
	} sample_t;

	typedef enum logic [1:0] {
		IN_PORT_A = 2'h0,
		IN_PORT_B = 2'h1,
		IN_RECEIVER = 2'h2,
		IN_RESERVED = 2'h3
	} input_sel_t;

	typedef enum logic [1:0] {
		CLK_MASTER = 2'h0,
		CLK_RECEIVER_IN = 2'h1,
		CLK_RECOVERED_OUT = 2'h2,
		CLK_RESERVED = 2'h3
	} refclk_sel_t;

	typedef enum logic [1:0] {
		DEEMPH_OFF = 2'h0,
		DEEMPH_48K = 2'h1,
		DEEMPH_44K1 = 2'h2,
		DEEMPH_32K = 2'h3
	} deemph_t;

	typedef struct packed {
		logic auto_deemph_enable;
		logic [1:0] manual_deemph_select;
		logic direct_downsample_bit;
		logic [1:0] group_delay_select;
	} control_two_t;

	typedef struct packed {
		logic track;
		logic mute;
		logic [1:0] src_refclk_select;
		logic [1:0] src_input_select;
	} control_one_t;

endpackage

// [core/atten_gain.sv]
// Applies a 0.5 dB-per-step attenuation to one signed audio sample.
`timescale 1ns/1ps
`include "src_ctl_defs.svh"

module atten_gain (
	input wire logic [7:0] steps,
	input wire logic signed [23:0] din,
	output logic signed [23:0] dout
);

	logic [7:0] shift_whole;
	logic [7:0] frac_step;
	logic [16:0] mant;
	logic signed [41:0] prod;
	logic signed [41:0] scaled;
	logic [7:0] shift_total;

	// Twelve half-dB steps make one 6.02 dB halving, done as a shift.
	assign shift_whole = steps / `ATTEN_STEPS_PER_SHIFT;
	assign frac_step = steps % `ATTEN_STEPS_PER_SHIFT;
	assign shift_total = shift_whole + `GAIN_FRAC_BITS;

	always_comb
	begin
		case (frac_step)
			8'h00: mant = 17'h10000;
			8'h01: mant = 17'h0F1AE;
			8'h02: mant = 17'h0E429;
			8'h03: mant = 17'h0D766;
			8'h04: mant = 17'h0CB59;
			8'h05: mant = 17'h0BFF9;
			8'h06: mant = 17'h0B53C;
			8'h07: mant = 17'h0AB19;
			8'h08: mant = 17'h0A186;
			8'h09: mant = 17'h0987D;
			8'h0A: mant = 17'h08FF6;
			default: mant = 17'h087E8;
		endcase
	end

	assign prod = din * $signed({1'b0, mant});
	assign scaled = prod >>> shift_total;
	// A zero setting passes the sample bit-exact.
	assign dout = (steps == 8'h00) ? din : scaled[23:0];

endmodule

// [core/deemph_select.sv]
// Chooses the effective de-emphasis mode from manual or channel-status input.
`timescale 1ns/1ps

module deemph_select (
	input wire logic auto_enable,
	input wire logic [1:0] manual_select,
	input wire logic [7:0] cs_byte0,
	input wire logic [7:0] cs_byte3,
	output src_ctl_pkg::deemph_t mode
);

	logic consumer;
	logic emph_5015;
	src_ctl_pkg::deemph_t auto_mode;

	// Consumer format only: bit 0 low, emphasis code 001 in bits 5..3.
	assign consumer = ~cs_byte0[0];
	assign emph_5015 = consumer & (cs_byte0[5:3] == 3'h1);

	always_comb
	begin
		auto_mode = src_ctl_pkg::DEEMPH_OFF;
		if (emph_5015)
		begin
			case (cs_byte3[3:0])
				4'h0: auto_mode = src_ctl_pkg::DEEMPH_44K1;
				4'h2: auto_mode = src_ctl_pkg::DEEMPH_48K;
				4'h3: auto_mode = src_ctl_pkg::DEEMPH_32K;
				default: auto_mode = src_ctl_pkg::DEEMPH_OFF;
			endcase
		end
	end

	// The manual field has no say while automatic mode is on.
	assign mode = auto_enable ? auto_mode :
		src_ctl_pkg::deemph_t'(manual_select);

endmodule

// [core/src_control_config.sv]
// Converter control registers and the input, mute and attenuation path.
`timescale 1ns/1ps
`include "src_ctl_defs.svh"

module src_control_config (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rd_valid,
	input wire src_ctl_pkg::sample_t port_a_in,
	input wire src_ctl_pkg::sample_t port_b_in,
	input wire src_ctl_pkg::sample_t receiver_in,
	input wire logic [7:0] cs_byte0,
	input wire logic [7:0] cs_byte3,
	output src_ctl_pkg::sample_t src_input,
	output src_ctl_pkg::sample_t sample_out,
	output src_ctl_pkg::refclk_sel_t refclk_select,
	output logic [6:0] prebuffer_depth,
	output logic direct_downsample,
	output src_ctl_pkg::deemph_t deemph_mode,
	output logic [7:0] atten_left_eff,
	output logic [7:0] atten_right_eff
);

	src_ctl_pkg::control_one_t one_reg;
	src_ctl_pkg::control_two_t two_reg;
	logic [7:0] left_attenuation_reg;
	logic [7:0] right_attenuation_reg;
	logic [1:0] page_reg;

	logic page_zero;
	logic wr_one;
	logic wr_two;
	logic wr_left;
	logic wr_right;
	logic wr_page;
	logic [7:0] one_next;
	logic [7:0] two_next;
	logic [7:0] one_read;
	logic [7:0] two_read;
	logic [7:0] rdata_next;

	src_ctl_pkg::input_sel_t in_sel;
	src_ctl_pkg::sample_t in_pick;
	src_ctl_pkg::refclk_sel_t clk_pick;
	logic [6:0] depth_pick;
	logic [7:0] left_steps;
	logic [7:0] right_steps;
	logic signed [23:0] left_att;
	logic signed [23:0] right_att;
	src_ctl_pkg::sample_t out_next;
	src_ctl_pkg::deemph_t deemph_pick;

	// The page register answers on every page; the rest only on page 0.
	assign page_zero = (page_reg == `PAGE_CONTROL);
	assign wr_page = reg_wr_en & (reg_addr == `ADDR_PAGE);
	assign wr_one = reg_wr_en & page_zero & (reg_addr == `ADDR_CONTROL_ONE);
	assign wr_two = reg_wr_en & page_zero & (reg_addr == `ADDR_CONTROL_TWO);
	assign wr_left = reg_wr_en & page_zero & (reg_addr == `ADDR_ATTEN_LEFT);
	assign wr_right = reg_wr_en & page_zero &
		(reg_addr == `ADDR_ATTEN_RIGHT);

	assign one_next = reg_wdata & `WMASK_CONTROL_ONE;
	assign two_next = reg_wdata & `WMASK_CONTROL_TWO;

	assign one_read = {1'b0, one_reg.track, 1'b0, one_reg.mute,
		one_reg.src_refclk_select, one_reg.src_input_select};
	assign two_read = {2'b00, two_reg};

	always_comb
	begin
		rdata_next = 8'h00;
		if (reg_addr == `ADDR_PAGE)
			rdata_next = {6'h00, page_reg};
		else if (page_zero)
		begin
			case (reg_addr)
				`ADDR_CONTROL_ONE: rdata_next = one_read;
				`ADDR_CONTROL_TWO: rdata_next = two_read;
				`ADDR_ATTEN_LEFT: rdata_next = left_attenuation_reg;
				`ADDR_ATTEN_RIGHT: rdata_next = right_attenuation_reg;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			one_reg <= src_ctl_pkg::control_one_t'(6'(`RESET_CONTROL_ONE));
			two_reg <= src_ctl_pkg::control_two_t'(6'(`RESET_CONTROL_TWO));
			left_attenuation_reg <= `RESET_ATTEN;
			right_attenuation_reg <= `RESET_ATTEN;
			page_reg <= `RESET_PAGE;
		end
		else
		begin
			if (wr_one)
				one_reg <= {one_next[6], one_next[4:0]};
			if (wr_two)
				two_reg <= two_next[5:0];
			if (wr_left)
				left_attenuation_reg <= reg_wdata;
			if (wr_right)
				right_attenuation_reg <= reg_wdata;
			if (wr_page)
				page_reg <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			reg_rdata <= 8'h00;
			reg_rd_valid <= 1'b0;
		end
		else
		begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en)
				reg_rdata <= rdata_next;
		end
	end

	// Source selection; the reserved code falls back to port A.
	assign in_sel = src_ctl_pkg::input_sel_t'(one_reg.src_input_select);

	always_comb
	begin
		case (in_sel)
			src_ctl_pkg::IN_PORT_B: in_pick = port_b_in;
			src_ctl_pkg::IN_RECEIVER: in_pick = receiver_in;
			default: in_pick = port_a_in;
		endcase
	end

	// The reserved clock code falls back to the master clock.
	always_comb
	begin
		case (one_reg.src_refclk_select)
			2'h1: clk_pick = src_ctl_pkg::CLK_RECEIVER_IN;
			2'h2: clk_pick = src_ctl_pkg::CLK_RECOVERED_OUT;
			default: clk_pick = src_ctl_pkg::CLK_MASTER;
		endcase
	end

	always_comb
	begin
		case (two_reg.group_delay_select)
			2'h1: depth_pick = `PREBUF_32;
			2'h2: depth_pick = `PREBUF_16;
			2'h3: depth_pick = `PREBUF_8;
			default: depth_pick = `PREBUF_64;
		endcase
	end

	assign left_steps = left_attenuation_reg;
	assign right_steps = one_reg.track ? left_attenuation_reg :
		right_attenuation_reg;

	atten_gain left_gain (
		.steps(left_steps),
		.din(src_input.left),
		.dout(left_att)
	);

	atten_gain right_gain (
		.steps(right_steps),
		.din(src_input.right),
		.dout(right_att)
	);

	deemph_select deemph (
		.auto_enable(two_reg.auto_deemph_enable),
		.manual_select(two_reg.manual_deemph_select),
		.cs_byte0(cs_byte0),
		.cs_byte3(cs_byte3),
		.mode(deemph_pick)
	);

	// Muting keeps the sample strobe so downstream timing is unchanged.
	always_comb
	begin
		out_next.valid = src_input.valid;
		out_next.left = one_reg.mute ? 24'sh000000 : left_att;
		out_next.right = one_reg.mute ? 24'sh000000 : right_att;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			src_input <= '0;
			sample_out <= '0;
			refclk_select <= src_ctl_pkg::CLK_MASTER;
			prebuffer_depth <= `PREBUF_64;
			direct_downsample <= 1'b0;
			deemph_mode <= src_ctl_pkg::DEEMPH_OFF;
			atten_left_eff <= `RESET_ATTEN;
			atten_right_eff <= `RESET_ATTEN;
		end
		else
		begin
			src_input <= in_pick;
			sample_out <= out_next;
			refclk_select <= clk_pick;
			prebuffer_depth <= depth_pick;
			direct_downsample <= two_reg.direct_downsample_bit;
			deemph_mode <= deemph_pick;
			atten_left_eff <= left_steps;
			atten_right_eff <= right_steps;
		end
	end

endmodule

// [verification/src_ctl_monitor.sv]
// Assertion checker for the converter control block.
`timescale 1ns/1ps
module src_ctl_monitor (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rd_valid,
	input wire src_ctl_pkg::sample_t port_a_in,
	input wire src_ctl_pkg::sample_t port_b_in,
	input wire src_ctl_pkg::sample_t receiver_in,
	input wire src_ctl_pkg::sample_t src_input,
	input wire src_ctl_pkg::refclk_sel_t refclk_select,
	input wire logic [6:0] prebuffer_depth,
	input wire logic direct_downsample,
	input wire src_ctl_pkg::deemph_t deemph_mode,
	input wire logic [7:0] atten_left_eff,
	input wire logic [7:0] atten_right_eff
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic [1:0] pg_reg;
	wire w1 = reg_wr_en && reg_addr == 7'h2D && pg_reg == 2'h0;
	wire w2 = reg_wr_en && reg_addr == 7'h2E && pg_reg == 2'h0;
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			pg_reg <= 2'h0;
		else if (reg_wr_en && reg_addr == 7'h7F)
			pg_reg <= reg_wdata[1:0];
	end
	property p_rdv;
		reg_rd_en |=> reg_rd_valid;
	endproperty
	property p_ins;
		1'b1 |=> src_input == $past(port_a_in) ||
			src_input == $past(port_b_in) || src_input == $past(receiver_in);
	endproperty
	property p_rst;
		$fell(sys_rst) |-> prebuffer_depth == 7'h40 && deemph_mode == 2'h0;
	endproperty
	property p_grp;
		w2 |=> ##1 prebuffer_depth == (7'h40 >> $past(reg_wdata[1:0], 2)) &&
			direct_downsample == $past(reg_wdata[2], 2);
	endproperty
	property p_dem;
		w2 && !reg_wdata[5] |=> ##1 deemph_mode == $past(reg_wdata[4:3], 2);
	endproperty
	property p_clk;
		w1 && reg_wdata[3:2] != 2'h3 |=> ##1
			refclk_select == $past(reg_wdata[3:2], 2);
	endproperty
	property p_trk;
		w1 && reg_wdata[6] |=> ##1 atten_right_eff == atten_left_eff;
	endproperty
	property p_unu;
		pg_reg == 2'h0 && reg_rd_en && reg_addr == 7'h2D |=>
			reg_rdata[7] == 1'b0 && reg_rdata[5] == 1'b0;
	endproperty
	property p_pag;
		pg_reg != 2'h0 && reg_rd_en && reg_addr == 7'h2E |=> reg_rdata == 8'h00;
	endproperty
	a_rdv: assert property (p_rdv) else $error("read valid missing");
	a_ins: assert property (p_ins) else $error("input path wrong");
	a_rst: assert property (p_rst) else $error("reset defaults wrong");
	a_grp: assert property (p_grp) else $error("delay or mode wrong");
	a_dem: assert property (p_dem) else $error("manual mode wrong");
	a_clk: assert property (p_clk) else $error("clock select wrong");
	a_trk: assert property (p_trk) else $error("tracking wrong");
	a_unu: assert property (p_unu) else $error("unused bits set");
	a_pag: assert property (p_pag) else $error("page gate broken");
	c_mute: cover property (w1 && reg_wdata[4]);
	c_auto: cover property (w2 && reg_wdata[5]);
	c_page: cover property (pg_reg != 2'h0 && reg_rd_en);
endmodule

bind src_control_config src_ctl_monitor i_mon (.clk_sys, .sys_rst,
	.reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
	.port_a_in, .port_b_in, .receiver_in, .src_input, .refclk_select,
	.prebuffer_depth, .direct_downsample, .deemph_mode, .atten_left_eff,
	.atten_right_eff);

// [verification/host_model.sv]
// Host processor model that drives the control register bus.
`timescale 1ns/1ps
module host_model (
	input wire logic clk_sys,
	output logic reg_wr_en = 1'b0,
	output logic reg_rd_en = 1'b0,
	output logic [6:0] reg_addr = 7'h00,
	output logic [7:0] reg_wdata = 8'h00,
	input wire logic [7:0] reg_rdata
);
	// Direct down-sampling is only set when the output rate is higher.
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
	begin
		@(posedge clk_sys);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr_en <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	end
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
	begin
		@(posedge clk_sys);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd_en <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk_sys);
		d = reg_rdata;
	end
	endtask
	task automatic page(input logic [1:0] p);
		wr(7'h7F, {6'h00, p});
	endtask
endmodule

// [verification/tb_top.sv]
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
`include "src_ctl_defs.svh"
module tb_top;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic reg_wr_en, reg_rd_en, reg_rd_valid, direct_downsample;
	logic [6:0] reg_addr, prebuffer_depth;
	logic [7:0] reg_wdata, reg_rdata, atten_left_eff, atten_right_eff, d, w;
	logic [7:0] cs_byte0 = 8'h08;
	logic [7:0] cs_byte3 = 8'h00;
	src_ctl_pkg::sample_t port_a_in = '0, port_b_in = '0, receiver_in = '0;
	src_ctl_pkg::sample_t src_input, sample_out;
	src_ctl_pkg::refclk_sel_t refclk_select;
	src_ctl_pkg::deemph_t deemph_mode;
	int error_cnt = 0, num_checks = 0, cyc = 0, i;
	host_model i_host (.clk_sys, .reg_wr_en, .reg_rd_en, .reg_addr,
		.reg_wdata, .reg_rdata);
	src_control_config i_dut (.clk_sys, .sys_rst, .reg_wr_en, .reg_rd_en,
		.reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid, .port_a_in,
		.port_b_in, .receiver_in, .cs_byte0, .cs_byte3, .src_input,
		.sample_out, .refclk_select, .prebuffer_depth, .direct_downsample,
		.deemph_mode, .atten_left_eff, .atten_right_eff);
	always #4 clk_sys = ~clk_sys;
	function automatic src_ctl_pkg::sample_t rnd();
		return {1'b1, 24'($urandom), 24'($urandom)};
	endfunction
	function automatic src_ctl_pkg::sample_t exp_in(int c);
		return c == 1 ? port_b_in : c == 2 ? receiver_in : port_a_in;
	endfunction
	function automatic logic [1:0] exp_auto(logic [7:0] b3);
		return b3 == 8'h00 ? 2'h2 : b3 == 8'h02 ? 2'h1 : b3 == 8'h03 ? 2'h3 : 2'h0;
	endfunction
	task automatic chk(input logic [48:0] got, input logic [48:0] exp);
	begin
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task automatic tally_and_finish();
	begin
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	end
	initial
	begin
		void'($urandom(32'hBD49));
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		i_host.rd(7'h2E, d);
		chk(d, 8'h00);
		chk(prebuffer_depth, `PREBUF_64);
		repeat (4)
		begin
			w = 8'($urandom);
			i_host.wr(7'h2D, w);
			i_host.rd(7'h2D, d);
			chk(d, w & `WMASK_CONTROL_ONE);
		end
		for (i = 0; i < 4; i++)
		begin
			i_host.wr(7'h2D, {4'h0, i[1:0], i[1:0]});
			port_a_in <= rnd();
			port_b_in <= rnd();
			receiver_in <= rnd();
			repeat (3) @(posedge clk_sys);
			chk(src_input, exp_in(i));
			chk(sample_out, exp_in(i));
			chk(refclk_select, i == 3 ? 0 : i);
			i_host.wr(7'h2E, {3'h0, i[1:0], i[0], i[1:0]});
			repeat (2) @(posedge clk_sys);
			chk(prebuffer_depth, `PREBUF_64 >> i);
			chk(direct_downsample, i[0]);
			chk(deemph_mode, i[1:0]);
			cs_byte3 <= 8'(i);
			i_host.wr(7'h2E, 8'h28);
			i_host.rd(7'h2E, d);
			chk(d, 8'h28);
			chk(deemph_mode, exp_auto(8'(i)));
		end
		cs_byte0 <= 8'h09;
		repeat (3) @(posedge clk_sys);
		chk(deemph_mode, src_ctl_pkg::DEEMPH_OFF);
		i_host.wr(7'h30, 8'h0C);
		i_host.wr(7'h31, 8'h18);
		i_host.wr(7'h2D, 8'hA0);
		repeat (2) @(posedge clk_sys);
		chk(atten_right_eff, 8'h18);
		chk(atten_left_eff, 8'h0C);
		chk(sample_out.left, $signed(port_a_in.left) >>> 1);
		chk(sample_out.right, $signed(port_a_in.right) >>> 2);
		i_host.wr(7'h2D, 8'h40);
		repeat (2) @(posedge clk_sys);
		chk(atten_right_eff, 8'h0C);
		chk(sample_out.right, $signed(port_a_in.right) >>> 1);
		i_host.wr(7'h2D, 8'h10);
		repeat (3) @(posedge clk_sys);
		chk(sample_out, {1'b1, 48'h0});
		i_host.page(2'h1);
		i_host.wr(7'h2D, 8'h01);
		i_host.rd(7'h2D, d);
		chk(d, 8'h00);
		i_host.rd(7'h2E, d);
		chk(d, 8'h00);
		i_host.page(2'h0);
		i_host.rd(7'h2D, d);
		chk(d, 8'h10);
		tally_and_finish();
	end
endmodule
